// ### core/pcsi_params.svh
// Constants for the program counter, return stack and indirect addressing block.
`ifndef PCSI_PARAMS_SVH
`define PCSI_PARAMS_SVH

`define PCSI_PC_W          13
`define PCSI_PC_LOW_W      8
`define PCSI_PC_UP_W       5
`define PCSI_JUMP_W        11
`define PCSI_STACK_DEPTH   8
`define PCSI_PTR_W         3
`define PCSI_DADDR_W       9
`define PCSI_DATA_W        8
`define PCSI_PC_RESET      13'h0000
`define PCSI_LATCH_RESET   8'h00
`define PCSI_PTR_RESET     3'h0
`define PCSI_INDIRECT_DATA_PORT_ADDR     7'h00
`define PCSI_LATCH_JUMP_HI 4
`define PCSI_LATCH_JUMP_LO 3

`endif

// ### core/pcsi_pkg.sv
// Types shared by the program counter, return stack and indirect addressing block.
package pcsi_pkg;

    // Program flow operation requested by the decoder for the current instruction.
    typedef enum logic [2:0] {
        PCSI_OP_STEP   = 3'h0,
        PCSI_OP_WR_LOW = 3'h1,
        PCSI_OP_JUMP   = 3'h3,
        PCSI_OP_CALL   = 3'h2,
        PCSI_OP_INTR   = 3'h6,
        PCSI_OP_RETURN = 3'h7,
        PCSI_OP_HOLD   = 3'h5
    } pcsi_op_t;

    // Kind of return; all three restore the counter the same way.
    typedef enum logic [1:0] {
        PCSI_RET_PLAIN   = 2'h0,
        PCSI_RET_LITERAL = 2'h1,
        PCSI_RET_INTR    = 2'h3
    } pcsi_ret_t;

endpackage : pcsi_pkg

// ### core/pcsi_stack.sv
// Eight-entry circular return stack with a hidden pointer.
`timescale 1ns/1ps
`include "pcsi_params.svh"

module pcsi_stack #(
    parameter int DEPTH = `PCSI_STACK_DEPTH,
    parameter int PTR_W = `PCSI_PTR_W,
    parameter int WIDTH = `PCSI_PC_W
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    output logic      [WIDTH-1:0] top_data
);

    logic [WIDTH-1:0] entry_ff [DEPTH];
    logic [PTR_W-1:0] ptr_ff;

    // Top of stack is the entry just below the pointer.
    assign top_data = entry_ff[ptr_ff - PTR_W'(1)];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ptr_ff <= `PCSI_PTR_RESET;
        end
        else if (push)
        begin
            ptr_ff <= ptr_ff + PTR_W'(1);
        end
        else if (pop)
        begin
            ptr_ff <= ptr_ff - PTR_W'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            entry_ff[ptr_ff] <= push_data;
        end
    end

    AST_STACK_WRAP: assert property (@(posedge core_clk) disable iff (rst)
        push && !pop |=> ptr_ff == $past(ptr_ff) + PTR_W'(1))
        else $error("stack pointer did not advance on push");

    AST_STACK_POP: assert property (@(posedge core_clk) disable iff (rst)
        pop && !push |=> ptr_ff == $past(ptr_ff) - PTR_W'(1))
        else $error("stack pointer did not retreat on pop");

endmodule : pcsi_stack

// ### core/pcsi_indirect.sv
// Indirect data address formation and self-reference masking.
`timescale 1ns/1ps
`include "pcsi_params.svh"

module pcsi_indirect #(
    parameter int DATA_W  = `PCSI_DATA_W,
    parameter int DADDR_W = `PCSI_DADDR_W
) (
    input  wire logic               indirect_bank_bit,
    input  wire logic [DATA_W-1:0]  file_select_pointer,
    input  wire logic [DATA_W-1:0]  mem_rd_data,
    output logic      [DADDR_W-1:0] eff_addr,
    output logic                    self_ref,
    output logic      [DATA_W-1:0]  rd_data
);

    assign eff_addr = {indirect_bank_bit, file_select_pointer};

    // Port sits at the same low address in every bank.
    assign self_ref = file_select_pointer[6:0] == `PCSI_INDIRECT_DATA_PORT_ADDR;

    assign rd_data = self_ref ? DATA_W'(0) : mem_rd_data;

endmodule : pcsi_indirect

// ### core/pcsi_core.sv
// Program counter, return stack and indirect data access of the processor core.
//
// Operation
// - Thirteen-bit program counter; low byte readable and writable.
// - Upper five bits reachable only through the high latch register.
// - Reset clears the program counter.
// - Low byte write loads latch bits 4..0 into upper bits together.
// - Call and jump take latch bits 4..3 as the top two bits.
// - Arithmetic on the low byte never carries into the latch.
// - Eight entry, 13-bit return stack with a hidden pointer.
// - Call pushes the program counter plus one; interrupt vectoring pushes it unchanged.
// - Any return restores the counter from the top entry and pops.
// - Push and pop leave the high latch unchanged.
// - Stack wraps; ninth push overwrites the first.
// - No overflow or underflow flag exists.
// - Indirect port has no storage; access goes to the pointed location.
// - Reading the port through itself returns zero.
// - Writing the port through itself changes no data.
// - Indirect address is bank bit over eight-bit pointer.
`timescale 1ns/1ps
`include "pcsi_params.svh"

module pcsi_core #(
    parameter int PC_W    = `PCSI_PC_W,
    parameter int DATA_W  = `PCSI_DATA_W,
    parameter int DADDR_W = `PCSI_DADDR_W,
    parameter int JUMP_W  = `PCSI_JUMP_W
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  pcsi_pkg::pcsi_op_t       flow_op,
    input  pcsi_pkg::pcsi_ret_t      ret_kind,
    input  wire logic [JUMP_W-1:0]   jump_operand,
    input  wire logic [PC_W-1:0]     intr_vector,
    input  wire logic [DATA_W-1:0]   low_wr_data,
    input  wire logic                latch_wr,
    input  wire logic [DATA_W-1:0]   latch_wr_data,
    input  wire logic                indirect_bank_bit,
    input  wire logic [DATA_W-1:0]   file_select_pointer,
    input  wire logic                ind_rd,
    input  wire logic                ind_wr,
    input  wire logic [DATA_W-1:0]   ind_wr_data,
    input  wire logic [DATA_W-1:0]   mem_rd_data,
    output logic      [PC_W-1:0]     program_counter,
    output logic      [DATA_W-1:0]   program_counter_low,
    output logic      [DATA_W-1:0]   program_counter_high_latch,
    output logic      [DADDR_W-1:0]  mem_addr,
    output logic                     mem_wr,
    output logic      [DATA_W-1:0]   mem_wr_data,
    output logic      [DATA_W-1:0]   ind_rd_data,
    output logic                     ind_rd_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [PC_W-1:0]    pc_ff;
    logic [PC_W-1:0]    nxt_pc;
    logic [DATA_W-1:0]  latch_ff;
    logic [PC_W-1:0]    stack_top;
    logic               push;
    logic               pop;
    logic [PC_W-1:0]    pc_plus_one;
    logic [DADDR_W-1:0] eff_addr;
    logic               self_ref;
    logic [DATA_W-1:0]  ind_rd_comb;
    logic [DADDR_W-1:0] mem_addr_ff;
    logic               mem_wr_ff;
    logic [DATA_W-1:0]  mem_wr_data_ff;
    logic [DATA_W-1:0]  ind_rd_data_ff;
    logic               ind_rd_valid_ff;

    function automatic logic [PC_W-1:0] pcsi_incr(input logic [PC_W-1:0] value);
        pcsi_incr = value + PC_W'(1);
    endfunction : pcsi_incr

    ////////////////////////////////////////////////////////////////////////
    // Program counter.

    assign pc_plus_one = pcsi_incr(pc_ff);

    assign push = (flow_op == pcsi_pkg::PCSI_OP_CALL) || (flow_op == pcsi_pkg::PCSI_OP_INTR);
    assign pop  = (flow_op == pcsi_pkg::PCSI_OP_RETURN);

    always_comb
    begin
        nxt_pc = pc_plus_one;
        case (flow_op)
            pcsi_pkg::PCSI_OP_STEP:
                nxt_pc = pc_plus_one;
            pcsi_pkg::PCSI_OP_WR_LOW:
                nxt_pc = {latch_ff[`PCSI_PC_UP_W-1:0], low_wr_data};
            pcsi_pkg::PCSI_OP_JUMP,
            pcsi_pkg::PCSI_OP_CALL:
                nxt_pc = {latch_ff[`PCSI_LATCH_JUMP_HI:`PCSI_LATCH_JUMP_LO], jump_operand};
            pcsi_pkg::PCSI_OP_INTR:
                nxt_pc = intr_vector;
            pcsi_pkg::PCSI_OP_RETURN:
                nxt_pc = stack_top;
            pcsi_pkg::PCSI_OP_HOLD:
                nxt_pc = pc_ff;
            default:
                nxt_pc = pc_plus_one;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pc_ff <= `PCSI_PC_RESET;
        end
        else
        begin
            pc_ff <= nxt_pc;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            latch_ff <= `PCSI_LATCH_RESET;
        end
        else if (latch_wr)
        begin
            latch_ff <= latch_wr_data;
        end
    end

    assign program_counter            = pc_ff;
    assign program_counter_low        = pc_ff[DATA_W-1:0];
    assign program_counter_high_latch = latch_ff;

    ////////////////////////////////////////////////////////////////////////
    // Return stack.

    // push the return address
    // An interrupt is taken in place of the instruction at pc_ff, so pc_ff is the resume point.
    pcsi_stack #(
        .DEPTH (`PCSI_STACK_DEPTH),
        .PTR_W (`PCSI_PTR_W),
        .WIDTH (PC_W)
    ) u_stack (
        .core_clk  (core_clk),
        .rst       (rst),
        .push      (push),
        .pop       (pop),
        .push_data (flow_op == pcsi_pkg::PCSI_OP_CALL ? pc_plus_one : pc_ff),
        .top_data  (stack_top)
    );

    ////////////////////////////////////////////////////////////////////////
    // Indirect data access.

    pcsi_indirect #(
        .DATA_W  (DATA_W),
        .DADDR_W (DADDR_W)
    ) u_indirect (
        .indirect_bank_bit   (indirect_bank_bit),
        .file_select_pointer (file_select_pointer),
        .mem_rd_data         (mem_rd_data),
        .eff_addr            (eff_addr),
        .self_ref            (self_ref),
        .rd_data             (ind_rd_comb)
    );

    // self write suppressed
    // The address and strobe are registered; memory sees them one cycle after the request.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mem_addr_ff    <= '0;
            mem_wr_ff      <= 1'b0;
            mem_wr_data_ff <= '0;
        end
        else
        begin
            mem_addr_ff    <= eff_addr;
            mem_wr_ff      <= ind_wr && !self_ref;
            mem_wr_data_ff <= ind_wr_data;
        end
    end

    // registered read answer
    // Memory answers the registered address, so the pointer must settle one cycle before a read.
    // This keeps the address off a long combinational path at the cost of that setup cycle.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ind_rd_data_ff  <= '0;
            ind_rd_valid_ff <= 1'b0;
        end
        else
        begin
            ind_rd_data_ff  <= ind_rd ? ind_rd_comb : DATA_W'(0);
            ind_rd_valid_ff <= ind_rd;
        end
    end

    assign mem_addr     = mem_addr_ff;
    assign mem_wr       = mem_wr_ff;
    assign mem_wr_data  = mem_wr_data_ff;
    assign ind_rd_data  = ind_rd_data_ff;
    assign ind_rd_valid = ind_rd_valid_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence pcsi_call_seq;
        flow_op == pcsi_pkg::PCSI_OP_CALL;
    endsequence

    sequence pcsi_ret_seq;
        flow_op == pcsi_pkg::PCSI_OP_RETURN;
    endsequence

    // Every return kind restores alike; the kind only tells which instruction the decoder ran.
    sequence pcsi_any_ret_seq;
        pcsi_ret_seq ##0 (ret_kind == pcsi_pkg::PCSI_RET_PLAIN || ret_kind == pcsi_pkg::PCSI_RET_LITERAL
            || ret_kind == pcsi_pkg::PCSI_RET_INTR);
    endsequence

    sequence pcsi_intr_seq;
        flow_op == pcsi_pkg::PCSI_OP_INTR;
    endsequence

    AST_RESET_ZERO: assert property (@(posedge core_clk)
        $fell(rst) |-> pc_ff == `PCSI_PC_RESET)
        else $error("program counter not zero after reset");

    AST_LOW_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        flow_op == pcsi_pkg::PCSI_OP_WR_LOW |=> pc_ff == {$past(latch_ff[4:0]), $past(low_wr_data)})
        else $error("low byte write did not load full counter");

    AST_JUMP_LOAD: assert property (@(posedge core_clk) disable iff (rst)
        flow_op == pcsi_pkg::PCSI_OP_JUMP |=> pc_ff == {$past(latch_ff[4:3]), $past(jump_operand)})
        else $error("jump target wrong");

    AST_CALL_RETURN: assert property (@(posedge core_clk) disable iff (rst)
        pcsi_call_seq ##1 pcsi_ret_seq |=> pc_ff == $past(pc_ff, 2) + PC_W'(1))
        else $error("return did not resume after call");

    AST_STEP_WRAP: assert property (@(posedge core_clk) disable iff (rst)
        flow_op == pcsi_pkg::PCSI_OP_STEP && !latch_wr |=> latch_ff == $past(latch_ff))
        else $error("latch changed without a write");

    AST_LATCH_STACK: assert property (@(posedge core_clk) disable iff (rst)
        (push || pop) && !latch_wr |=> $stable(latch_ff))
        else $error("stack action disturbed latch");

    AST_SELF_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        ind_wr && self_ref |=> !mem_wr)
        else $error("self referencing write reached memory");

    AST_SELF_READ: assert property (@(posedge core_clk) disable iff (rst)
        ind_rd && self_ref |=> ind_rd_valid && ind_rd_data == 8'h00)
        else $error("self referencing read not zero");

    AST_IND_ADDR: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> mem_addr == {$past(indirect_bank_bit), $past(file_select_pointer)})
        else $error("indirect address wrong");

    AST_STEP_INC: assert property (@(posedge core_clk) disable iff (rst)
        flow_op == pcsi_pkg::PCSI_OP_STEP |=> pc_ff == $past(pc_ff) + PC_W'(1))
        else $error("program counter did not advance by one");

    AST_RESET_CLEAR: assert property (@(posedge core_clk)
        $fell(rst) |-> latch_ff == `PCSI_LATCH_RESET && !mem_wr && !ind_rd_valid)
        else $error("latch or strobes not clear after reset");

    AST_CALL_LOAD: assert property (@(posedge core_clk) disable iff (rst)
        pcsi_call_seq |=> pc_ff == {$past(latch_ff[4:3]), $past(jump_operand)})
        else $error("call target wrong");

    AST_CALL_PUSH: assert property (@(posedge core_clk) disable iff (rst)
        pcsi_call_seq |=> stack_top == $past(pc_ff) + PC_W'(1))
        else $error("call did not push the next address");

    AST_INTR_PUSH: assert property (@(posedge core_clk) disable iff (rst)
        pcsi_intr_seq |=> stack_top == $past(pc_ff) && pc_ff == $past(intr_vector))
        else $error("interrupt did not push the resume point");

    AST_INTR_RESUME: assert property (@(posedge core_clk) disable iff (rst)
        pcsi_intr_seq ##1 (flow_op == pcsi_pkg::PCSI_OP_STEP) ##1 pcsi_ret_seq |=> pc_ff == $past(pc_ff, 3))
        else $error("return did not resume after interrupt");

    AST_RET_RESTORE: assert property (@(posedge core_clk) disable iff (rst)
        pcsi_any_ret_seq |=> pc_ff == $past(stack_top))
        else $error("return did not restore the top entry");

endmodule : pcsi_core

// ### verification/pcsi_mem_model.sv
// Data memory model answering the core's indirect accesses.
`timescale 1ns/1ps
`include "pcsi_params.svh"

module pcsi_mem_model (
    input  wire logic [`PCSI_DADDR_W-1:0] mem_addr,
    input  wire logic                     core_clk,
    input  wire logic                     mem_wr,
    input  wire logic [`PCSI_DATA_W-1:0]  mem_wr_data,
    output logic      [`PCSI_DATA_W-1:0]  mem_rd_data
);
    logic [`PCSI_DATA_W-1:0] mem [0:(1 << `PCSI_DADDR_W)-1];

    // Unwritten places hold an address-derived pattern, so a read from the wrong place shows.
    initial
    begin
        for (int a = 0; a < (1 << `PCSI_DADDR_W); a++)
        begin
            mem[a] = 8'(a) ^ 8'hA5;
        end
    end

    always @(posedge core_clk)
    begin
        if (mem_wr)
        begin
            mem[mem_addr] <= mem_wr_data;
        end
    end

    // The read port is combinational on the registered address, as the core expects.
    assign mem_rd_data = mem[mem_addr];
endmodule : pcsi_mem_model

// ### verification/pcsi_core_tb.sv
// Self-checking bench for the program counter, return stack and indirect access block.
`timescale 1ns/1ps
`include "pcsi_params.svh"

module pcsi_core_tb;
    typedef struct {
        logic [7:0]         latch;
        pcsi_pkg::pcsi_op_t op;
        logic [7:0]         low;
        logic [10:0]        jop;
        logic [12:0]        pc;
    } pcsi_row_t;

    logic                core_clk = 1'b0;
    logic                rst = 1'b1;
    pcsi_pkg::pcsi_op_t  flow_op = pcsi_pkg::PCSI_OP_HOLD;
    pcsi_pkg::pcsi_ret_t ret_kind = pcsi_pkg::PCSI_RET_PLAIN;
    logic [10:0]         jump_operand = 11'h000;
    logic [12:0]         intr_vector = 13'h0000;
    logic [7:0]          low_wr_data = 8'h00;
    logic                latch_wr = 1'b0;
    logic [7:0]          latch_wr_data = 8'h00;
    logic                indirect_bank_bit = 1'b0;
    logic [7:0]          file_select_pointer = 8'h00;
    logic                ind_rd = 1'b0;
    logic                ind_wr = 1'b0;
    logic [7:0]          ind_wr_data = 8'h00;
    logic [7:0]          mem_rd_data;
    logic [12:0]         program_counter;
    logic [7:0]          program_counter_low;
    logic [7:0]          program_counter_high_latch;
    logic [8:0]          mem_addr;
    logic                mem_wr;
    logic [7:0]          mem_wr_data;
    logic [7:0]          ind_rd_data;
    logic                ind_rd_valid;
    int                  err_total = 0;
    int                  samples_checked = 0;
    pcsi_row_t           rows [8];
    pcsi_pkg::pcsi_ret_t kinds [3];
    logic [12:0]         pushed [9];
    logic [12:0]         back_to;

    always #5 core_clk = ~core_clk;

    pcsi_core pcsi_core_i (.core_clk(core_clk), .rst(rst), .flow_op(flow_op), .ret_kind(ret_kind),
        .jump_operand(jump_operand), .intr_vector(intr_vector), .low_wr_data(low_wr_data),
        .latch_wr(latch_wr), .latch_wr_data(latch_wr_data), .indirect_bank_bit(indirect_bank_bit),
        .file_select_pointer(file_select_pointer), .ind_rd(ind_rd), .ind_wr(ind_wr),
        .ind_wr_data(ind_wr_data), .mem_rd_data(mem_rd_data), .program_counter(program_counter),
        .program_counter_low(program_counter_low), .program_counter_high_latch(program_counter_high_latch),
        .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data), .ind_rd_data(ind_rd_data),
        .ind_rd_valid(ind_rd_valid));

    pcsi_mem_model pcsi_mem_model_i (.core_clk(core_clk), .mem_addr(mem_addr), .mem_wr(mem_wr),
        .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        if (err_total == 0 && samples_checked > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // The caller restores HOLD itself, so back-to-back ops never assign flow_op twice in a step.
    task automatic op_cyc(input pcsi_pkg::pcsi_op_t op, input logic [7:0] low, input logic [10:0] jop);
        flow_op = op;
        low_wr_data = low;
        jump_operand = jop;
        @(negedge core_clk);
    endtask : op_cyc

    task automatic set_latch(input logic [7:0] v);
        latch_wr = 1'b1;
        latch_wr_data = v;
        @(negedge core_clk);
        latch_wr = 1'b0;
    endtask : set_latch

    task automatic chk_pc(input logic [12:0] exp, input logic [7:0] latch);
        chk("program_counter", 16'(program_counter), 16'(exp));
        chk("program_counter_low", 16'(program_counter_low), 16'(exp[7:0]));
        chk("program_counter_high_latch", 16'(program_counter_high_latch), 16'(latch));
    endtask : chk_pc

    // The pointer settles one cycle ahead because the memory reads on the registered address.
    task automatic ind_read(input logic bank, input logic [7:0] ptr, input logic [7:0] exp);
        indirect_bank_bit = bank;
        file_select_pointer = ptr;
        @(negedge core_clk);
        ind_rd = 1'b1;
        @(negedge core_clk);
        ind_rd = 1'b0;
        chk("ind_rd_valid", 16'(ind_rd_valid), 16'h0001);
        chk("ind_rd_data", 16'(ind_rd_data), 16'(exp));
    endtask : ind_read

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rows[0] = '{8'h1F, pcsi_pkg::PCSI_OP_WR_LOW, 8'hAB, 11'h000, 13'h1FAB};
        rows[1] = '{8'hE7, pcsi_pkg::PCSI_OP_WR_LOW, 8'h12, 11'h000, 13'h0712};
        rows[2] = '{8'h18, pcsi_pkg::PCSI_OP_JUMP, 8'h00, 11'h7FF, 13'h1FFF};
        rows[3] = '{8'h08, pcsi_pkg::PCSI_OP_JUMP, 8'h00, 11'h123, 13'h0923};
        rows[4] = '{8'h17, pcsi_pkg::PCSI_OP_JUMP, 8'h00, 11'h055, 13'h1055};
        rows[5] = '{8'h02, pcsi_pkg::PCSI_OP_WR_LOW, 8'hFF, 11'h000, 13'h02FF};
        rows[6] = '{8'h02, pcsi_pkg::PCSI_OP_WR_LOW, 8'h00, 11'h000, 13'h0200};
        rows[7] = '{8'h02, pcsi_pkg::PCSI_OP_STEP, 8'h00, 11'h000, 13'h0201};
        kinds = '{pcsi_pkg::PCSI_RET_PLAIN, pcsi_pkg::PCSI_RET_LITERAL, pcsi_pkg::PCSI_RET_INTR};
        repeat (20) @(negedge core_clk);
        chk_pc(13'h0000, 8'h00);
        rst = 1'b0;
        foreach (rows[i])
        begin
            set_latch(rows[i].latch);
            op_cyc(rows[i].op, rows[i].low, rows[i].jop);
            chk_pc(rows[i].pc, rows[i].latch);
            op_cyc(pcsi_pkg::PCSI_OP_HOLD, 8'h00, 11'h000);
        end
        // Nine calls overflow the stack; the ninth return then wraps back onto the newest entry.
        set_latch(8'h10);
        op_cyc(pcsi_pkg::PCSI_OP_WR_LOW, 8'h40, 11'h000);
        back_to = 13'h1041;
        for (int i = 0; i < 9; i++)
        begin
            pushed[i] = back_to;
            op_cyc(pcsi_pkg::PCSI_OP_CALL, 8'h00, 11'(16 * i + 5));
            back_to = 13'h1000 + 13'(16 * i + 5) + 13'h0001;
            chk_pc(13'h1000 + 13'(16 * i + 5), 8'h10);
        end
        for (int i = 0; i < 9; i++)
        begin
            ret_kind = kinds[i % 3];
            op_cyc(pcsi_pkg::PCSI_OP_RETURN, 8'h00, 11'h000);
            chk_pc(pushed[(i < 8) ? 8 - i : 8], 8'h10);
        end
        intr_vector = 13'h0004;
        op_cyc(pcsi_pkg::PCSI_OP_INTR, 8'h00, 11'h000);
        chk_pc(13'h0004, 8'h10);
        op_cyc(pcsi_pkg::PCSI_OP_STEP, 8'h00, 11'h000);
        chk_pc(13'h0005, 8'h10);
        ret_kind = pcsi_pkg::PCSI_RET_INTR;
        op_cyc(pcsi_pkg::PCSI_OP_RETURN, 8'h00, 11'h000);
        chk_pc(pushed[8], 8'h10);
        flow_op = pcsi_pkg::PCSI_OP_HOLD;
        // Back-to-back indirect writes, then one aimed at the port itself.
        indirect_bank_bit = 1'b1;
        file_select_pointer = 8'h25;
        ind_wr_data = 8'h5A;
        ind_wr = 1'b1;
        @(negedge core_clk);
        chk("mem_addr", 16'(mem_addr), 16'h0125);
        chk("mem_wr", 16'(mem_wr), 16'h0001);
        chk("mem_wr_data", 16'(mem_wr_data), 16'h005A);
        file_select_pointer = 8'h26;
        ind_wr_data = 8'hC3;
        @(negedge core_clk);
        chk("mem_addr", 16'(mem_addr), 16'h0126);
        chk("mem_wr", 16'(mem_wr), 16'h0001);
        indirect_bank_bit = 1'b0;
        file_select_pointer = 8'h80;
        @(negedge core_clk);
        chk("mem_wr", 16'(mem_wr), 16'h0000);
        ind_wr = 1'b0;
        @(negedge core_clk);
        chk("mem_080", 16'(pcsi_mem_model_i.mem[128]), 16'h0025);
        ind_read(1'b1, 8'h25, 8'h5A);
        ind_read(1'b1, 8'h26, 8'hC3);
        ind_read(1'b0, 8'h25, 8'h80);
        ind_read(1'b1, 8'h00, 8'h00);
        ind_read(1'b0, 8'h80, 8'h00);
        rst = 1'b1;
        @(negedge core_clk);
        chk_pc(13'h0000, 8'h00);
        rst = 1'b0;
        op_cyc(pcsi_pkg::PCSI_OP_STEP, 8'h00, 11'h000);
        chk_pc(13'h0001, 8'h00);
        final_report();
    end
endmodule : pcsi_core_tb
